// ---- hdl/fifo_ctl.sv ----
`timescale 1ns/10ps
// Functional notes
// - reset load pin plus selects choose offset
// - after reset load pin gates offsets
// - memory access only with load high
// - mark records current read pointer
// - master reset zeros pointers and output
// - master reset latches all configuration
// - output enable drives outputs through three flops
// - during resets only enable floats outputs
// - widths from input and output selects
// - 18-bit output, low 9 in narrow mode
// - almost empty low below offset n
// - almost full high above offset m
// - flag timing select sampled at reset
// - partial reset keeps settings, clears data
// - sync read on clock edge with enable
// - load low outputs offset registers
// - async read on strobe rising edge
// - async read select sampled at reset
// - retransmit returns to zero or mark
module fifo_ctl
   import fifo_ctl_pkg::*;
#(
   parameter int AW = fifo_ctl_pkg::DEPTH_LOG2
)
(
   input wire logic sys_clk, // system clock
   input wire logic arst_n, // async reset
   input wire logic master_reset_in, // master reset, active high
   input wire logic partial_reset_in, // partial reset, active high
   input wire logic offset_load, // offset-load pin, low selects offsets
   input wire logic default_offset_sel_lo, // default offset select
   input wire logic default_offset_sel_hi, // default offset select
   input wire logic fall_through_mode, // timing mode strap
   input wire logic input_width_select, // write width select
   input wire logic output_width_select, // read width select
   input wire logic async_read_select, // high is sync read
   input wire logic flag_timing_select, // high is sync flags
   input wire logic read_clk_in, // read clock or strobe
   input wire logic read_enable_in, // read enable, active high for sync read, active low for async read
   input wire logic write_clk_in, // write strobe for pointer
   input wire logic write_enable_in, // write enable
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] write_data_in, // write data
   input wire logic mark_in, // mark read position
   input wire logic retransmit_in, // retransmit request
   input wire logic output_enable_n, // output drive enable, active low
   output logic [fifo_ctl_pkg::DATA_W-1:0] read_data_out, // output register
   output logic read_data_oe, // outputs driven
   output logic almost_empty_flag, // low when nearly empty
   output logic almost_full_flag, // low when nearly full
   output logic [1:0] width_cfg_out // latched width combination
);
   import fifo_ctl_pkg::*;

   // straps and strobes share one chain so their relative timing survives the crossing
   localparam int NS = 13;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [NS-1:0] raw;
   assign raw = {master_reset_in, partial_reset_in, offset_load, default_offset_sel_lo,
      default_offset_sel_hi, fall_through_mode, input_width_select, output_width_select,
      async_read_select, flag_timing_select, read_clk_in, read_enable_in, write_clk_in};

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   logic hard_rst, soft_rst, load_pin, fs0, fs1;
   logic ft_strap, in_w_strap, out_w_strap, sync_rd_strap, flag_strap;
   logic rclk, ren, wclk;
   assign {hard_rst, soft_rst, load_pin, fs0, fs1, ft_strap, in_w_strap, out_w_strap,
      sync_rd_strap, flag_strap, rclk, ren, wclk} = s2_q;

   logic oe_n_s1_q, oe_n_q, mark_s1_q, mark_q, retx_s1_q, retx_q, wen_s1_q, wen_q;
   logic [DATA_W-1:0] wd_s1_q, wd_q;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // enable chain idles at the undriven level
         {oe_n_s1_q, oe_n_q, mark_s1_q, mark_q} <= 4'hC;
         {retx_s1_q, retx_q, wen_s1_q, wen_q} <= 4'h0;
         wd_s1_q <= QOUT_RST;
         wd_q <= QOUT_RST;
      end
      else
      begin
         oe_n_s1_q <= output_enable_n;
         oe_n_q <= oe_n_s1_q;
         mark_s1_q <= mark_in;
         mark_q <= mark_s1_q;
         retx_s1_q <= retransmit_in;
         retx_q <= retx_s1_q;
         wen_s1_q <= write_enable_in;
         wen_q <= wen_s1_q;
         wd_s1_q <= write_data_in;
         wd_q <= wd_s1_q;
      end
   end

   logic rclk_q, wclk_q;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rclk_q <= 1'b0;
         wclk_q <= 1'b0;
      end
      else
      begin
         rclk_q <= rclk;
         wclk_q <= wclk;
      end
   end
   // detectors reset to the strobes' idle low, so no false edge follows reset
   logic rise_r, rise_w;
   assign rise_r = rclk && !rclk_q;
   assign rise_w = wclk && !wclk_q;

   // configuration latched while master reset is held, frozen after
   cfg_s cfg_q;
   logic [OFFSET_W-1:0] empty_off_q, full_off_q;
   logic [OFFSET_W-1:0] def_off;
   always_comb
   begin
      unique case ({load_pin, fs1, fs0})
         3'd0: def_off = DEF_OFFSET_0;
         3'd1: def_off = DEF_OFFSET_1;
         3'd2: def_off = DEF_OFFSET_2;
         3'd3: def_off = DEF_OFFSET_3;
         3'd4: def_off = DEF_OFFSET_4;
         3'd5: def_off = DEF_OFFSET_5;
         3'd6: def_off = DEF_OFFSET_6;
         3'd7: def_off = DEF_OFFSET_7;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_q <= CFG_RST;
         empty_off_q <= '0;
         full_off_q <= '0;
      end
      else if (hard_rst)
      begin
         cfg_q.fall_through <= ft_strap && sync_rd_strap;
         cfg_q.in_wide <= in_w_strap;
         cfg_q.out_wide <= out_w_strap;
         cfg_q.sync_read <= sync_rd_strap;
         cfg_q.sync_flags <= flag_strap;
         cfg_q.serial_prog <= load_pin;
         empty_off_q <= def_off;
         full_off_q <= def_off;
      end
   end

   // pointers: one extra bit distinguishes full from empty
   logic [AW:0] wptr_q, rptr_q, mark_ptr_q;
   logic mark_valid_q;
   logic rd_edge, rd_mem, rd_off, off_sel_q;
   // sync read needs enable; async read needs enable held low
   assign rd_edge = rise_r && (cfg_q.sync_read ? ren : !ren);
   logic empty;
   assign empty = (wptr_q == rptr_q);
   assign rd_mem = rd_edge && load_pin && !empty && !hard_rst && !soft_rst;
   assign rd_off = rd_edge && !load_pin && !hard_rst && !soft_rst;

   logic [AW:0] count, free;
   assign count = wptr_q - rptr_q;
   assign free = (AW+1)'(1 << AW) - count;
   logic full;
   assign full = count[AW];

   // no reset on storage; the pointers alone say which words are valid
   logic [DATA_W-1:0] mem_q [0:(1<<AW)-1];
   always_ff @(posedge sys_clk)
   begin
      if (rise_w && wen_q && load_pin && !full && !hard_rst && !soft_rst)
         mem_q[wptr_q[AW-1:0]] <= wd_q;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         wptr_q <= '0;
      else if (hard_rst || soft_rst)
         wptr_q <= '0;
      else if (rise_w && wen_q && load_pin && !full)
         wptr_q <= wptr_q + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         rptr_q <= '0;
      else if (hard_rst || soft_rst)
         rptr_q <= '0;
      // retransmit wins over a read on the same strobe edge
      else if (rise_r && retx_q)
         rptr_q <= mark_valid_q ? mark_ptr_q : (AW+1)'(RPTR_ON_RETX);
      else if (rd_mem)
         rptr_q <= rptr_q + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mark_ptr_q <= '0;
         mark_valid_q <= 1'b0;
      end
      else if (hard_rst || soft_rst)
         mark_valid_q <= 1'b0;
      else if (mark_q)
      begin
         mark_ptr_q <= rptr_q;
         mark_valid_q <= 1'b1;
      end
   end

   // output register; offset reads alternate empty then full offset
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         read_data_out <= QOUT_RST;
         off_sel_q <= 1'b0;
      end
      else if (hard_rst || soft_rst)
      begin
         read_data_out <= QOUT_RST;
         off_sel_q <= 1'b0;
      end
      else if (rd_off)
      begin
         read_data_out <= DATA_W'(off_sel_q ? full_off_q : empty_off_q);
         off_sel_q <= !off_sel_q;
      end
      else if (rd_mem)
      begin
         if (cfg_q.out_wide)
            read_data_out <= mem_q[rptr_q[AW-1:0]];
         else
            read_data_out <= {{(DATA_W-HALF_W){1'b0}}, mem_q[rptr_q[AW-1:0]][HALF_W-1:0]};
      end
   end

   // output enable only; resets never float the bus
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         read_data_oe <= 1'b0;
      else
         read_data_oe <= !oe_n_q;
   end

   // flags: async mode updates each cycle, sync mode on read clock edges
   logic ae_d, af_d;
   // widen the counts instead of cutting the offsets, so large offsets never alias
   logic [OFFSET_W-1:0] count_w, free_w;
   assign count_w = OFFSET_W'(count);
   assign free_w = OFFSET_W'(free);
   assign ae_d = (count_w >= empty_off_q);
   assign af_d = (free_w > full_off_q);
   // sync flags trade latency for a flag that moves only with the reader's clock or while a reset is held
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         almost_empty_flag <= 1'b0;
         almost_full_flag <= 1'b1;
      end
      else if (!cfg_q.sync_flags || rise_r || hard_rst || soft_rst)
      begin
         almost_empty_flag <= ae_d;
         almost_full_flag <= af_d;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         width_cfg_out <= WIDTH_9_TO_9;
      else
         width_cfg_out <= {cfg_q.in_wide, cfg_q.out_wide};
   end
endmodule : fifo_ctl

// ---- hdl/fifo_ctl_pkg.sv ----
package fifo_ctl_pkg;
   localparam int DEPTH_LOG2 = 4;
   localparam int DATA_W = 18;
   localparam int HALF_W = 9;
   localparam int PTR_RST = 0;
   localparam logic [DATA_W-1:0] QOUT_RST = 18'h0_0000;
   localparam int RPTR_ON_RETX = 0;
   localparam int OFFSET_W = 16;
   // default offset table, index {offset_load, sel_hi, sel_lo}
   localparam logic [15:0] DEF_OFFSET_0 = 16'h0007;
   localparam logic [15:0] DEF_OFFSET_1 = 16'h000F;
   localparam logic [15:0] DEF_OFFSET_2 = 16'h001F;
   localparam logic [15:0] DEF_OFFSET_3 = 16'h003F;
   localparam logic [15:0] DEF_OFFSET_4 = 16'h0001;
   localparam logic [15:0] DEF_OFFSET_5 = 16'h0003;
   localparam logic [15:0] DEF_OFFSET_6 = 16'h007F;
   localparam logic [15:0] DEF_OFFSET_7 = 16'h00FF;

   typedef enum logic [1:0]
   {
      WIDTH_9_TO_9 = 2'b00,
      WIDTH_9_TO_18 = 2'b01,
      WIDTH_18_TO_9 = 2'b10,
      WIDTH_18_TO_18 = 2'b11
   } width_cfg_e;

   typedef struct packed
   {
      logic fall_through;
      logic in_wide;
      logic out_wide;
      logic sync_read;
      logic sync_flags;
      logic serial_prog;
   } cfg_s;

   localparam cfg_s CFG_RST = '{default: 1'b0};
endpackage : fifo_ctl_pkg

// ---- dv/fifo_ctl_asserts.sv ----
`timescale 1ns/10ps
module fifo_ctl_asserts
#(
   parameter int AW = 4
)
(
   input wire logic sys_clk, // clock
   input wire logic arst_n, // reset
   input wire logic master_reset_in, // mrst
   input wire logic partial_reset_in, // prst
   input wire logic input_width_select, // strap
   input wire logic output_width_select, // strap
   input wire logic read_clk_in, // rclk
   input wire logic output_enable_n, // oe pin
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] read_data_out, // data
   input wire logic read_data_oe, // drive
   input wire logic almost_empty_flag, // ae
   input wire logic [1:0] width_cfg_out // widths
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // resets pass a two-stage synchroniser, so checks wait for them to land
   sequence s_mst_on; master_reset_in [*5]; endsequence
   sequence s_run; (!master_reset_in) [*6]; endsequence
   property p_mst_clear; s_mst_on |-> read_data_out == '0; endproperty
   a_mst_clear: assert property (p_mst_clear) else $error("data kept in master reset");
   property p_ae; s_mst_on |-> !almost_empty_flag; endproperty
   a_ae: assert property (p_ae) else $error("empty not flagged");
   property p_prs; partial_reset_in [*5] |-> read_data_out == '0; endproperty
   a_prs: assert property (p_prs) else $error("data kept in partial reset");
   property p_wid;
      (master_reset_in && $stable({input_width_select, output_width_select})) [*5]
      |-> width_cfg_out == {input_width_select, output_width_select}; endproperty
   a_wid: assert property (p_wid) else $error("widths not latched");
   property p_hold; s_run |-> $stable(width_cfg_out); endproperty
   a_hold: assert property (p_hold) else $error("widths moved");
   property p_nar; s_run ##0 !width_cfg_out[0] |-> read_data_out[17:9] == '0; endproperty
   a_nar: assert property (p_nar) else $error("narrow upper bits set");
   // three flops to the output, plus one sample for the cycle reset lets go
   property p_oe; $stable(output_enable_n) [*5] |-> read_data_oe == !output_enable_n; endproperty
   a_oe: assert property (p_oe) else $error("drive not from enable");
   property p_rd;
      (!read_clk_in && !master_reset_in && !partial_reset_in) [*6] |-> $stable(read_data_out);
   endproperty
   a_rd: assert property (p_rd) else $error("data moved without read");
endmodule : fifo_ctl_asserts

bind fifo_ctl fifo_ctl_asserts #(.AW(AW)) chk (
   .sys_clk(sys_clk),
   .arst_n(arst_n),
   .master_reset_in(master_reset_in),
   .partial_reset_in(partial_reset_in),
   .input_width_select(input_width_select),
   .output_width_select(output_width_select),
   .read_clk_in(read_clk_in),
   .output_enable_n(output_enable_n),
   .read_data_out(read_data_out),
   .read_data_oe(read_data_oe),
   .almost_empty_flag(almost_empty_flag),
   .width_cfg_out(width_cfg_out)
);

// ---- dv/fifo_far_end.sv ----
`timescale 1ns/10ps
module fifo_far_end
   import fifo_ctl_pkg::*;
(
   output logic write_clk_in, // write strobe
   output logic write_enable_in, // write enable
   output logic [fifo_ctl_pkg::DATA_W-1:0] write_data_in, // write word
   output logic read_clk_in, // read clock or strobe
   output logic read_enable_in // read enable
);
   initial
   begin
      write_clk_in <= 1'h0;
      write_enable_in <= 1'h0;
      write_data_in <= 18'h0_0000;
      read_clk_in <= 1'h0;
      read_enable_in <= 1'h0;
   end
   // write strobes are 72 ns cycles, read strobes 64 ns, and stand still between transfers
   task automatic put(input logic [DATA_W-1:0] w);
      write_data_in <= w;
      write_enable_in <= 1'h1;
      #16 write_clk_in <= 1'h1;
      #32 write_clk_in <= 1'h0;
      #16 write_enable_in <= 1'h0;
      // released bus shows the inverse so a stale word cannot pass
      write_data_in <= ~w;
      // idle gap so back-to-back calls never touch a pin twice in one step
      #8;
   endtask : put
   task automatic get(input logic en);
      read_enable_in <= en;
      #16 read_clk_in <= 1'h1;
      #32 read_clk_in <= 1'h0;
      #16 read_enable_in <= 1'h0;
   endtask : get
endmodule : fifo_far_end

// ---- dv/tb_fifo_ctl.sv ----
`timescale 1ns/10ps
module tb_fifo_ctl;
   import fifo_ctl_pkg::*;
   logic sys_clk, read_clk_in, read_enable_in, write_clk_in, write_enable_in;
   logic read_data_oe, almost_empty_flag, almost_full_flag;
   logic [DATA_W-1:0] write_data_in, read_data_out;
   logic [1:0] width_cfg_out;
   logic arst_n = 1'h0, offset_load = 1'h1, output_enable_n = 1'h0, mark_in = 1'h0;
   logic master_reset_in = 1'h0, partial_reset_in = 1'h0, retransmit_in = 1'h0;
   logic default_offset_sel_lo = 1'h0, default_offset_sel_hi = 1'h0, fall_through_mode = 1'h0;
   logic input_width_select = 1'h0, output_width_select = 1'h0, async_read_select = 1'h0;
   logic flag_timing_select = 1'h0;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   fifo_ctl dut (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .master_reset_in(master_reset_in),
      .partial_reset_in(partial_reset_in),
      .offset_load(offset_load),
      .default_offset_sel_lo(default_offset_sel_lo),
      .default_offset_sel_hi(default_offset_sel_hi),
      .fall_through_mode(fall_through_mode),
      .input_width_select(input_width_select),
      .output_width_select(output_width_select),
      .async_read_select(async_read_select),
      .flag_timing_select(flag_timing_select),
      .read_clk_in(read_clk_in),
      .read_enable_in(read_enable_in),
      .write_clk_in(write_clk_in),
      .write_enable_in(write_enable_in),
      .write_data_in(write_data_in),
      .mark_in(mark_in),
      .retransmit_in(retransmit_in),
      .output_enable_n(output_enable_n),
      .read_data_out(read_data_out),
      .read_data_oe(read_data_oe),
      .almost_empty_flag(almost_empty_flag),
      .almost_full_flag(almost_full_flag),
      .width_cfg_out(width_cfg_out)
   );
   fifo_far_end far (
      .write_clk_in(write_clk_in),
      .write_enable_in(write_enable_in),
      .write_data_in(write_data_in),
      .read_clk_in(read_clk_in),
      .read_enable_in(read_enable_in)
   );
   initial
   begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic check_word(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word
   task automatic check_bit(input string what, input logic exp, input logic got);
      check_word(what, {17'h0_0000, exp}, {17'h0_0000, got});
   endtask : check_bit
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic mreset(input logic load_lvl, input logic [6:0] s);
      offset_load <= load_lvl;
      {default_offset_sel_hi, default_offset_sel_lo, fall_through_mode, input_width_select,
         output_width_select, async_read_select, flag_timing_select} <= s;
      master_reset_in <= 1'h1;
      tick(8);
      master_reset_in <= 1'h0;
      offset_load <= 1'h1;
      tick(8);
   endtask : mreset
   task automatic read_check(input logic en, input logic [17:0] exp);
      far.get(en);
      tick(1);
      check_word("read", exp, read_data_out);
   endtask : read_check
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   initial
   begin
      tick(5);
      arst_n <= 1'h1;
      mreset(1'h1, 7'h0E);
      check_word("widths", 18'h0_0003, {16'h0000, width_cfg_out});
      check_word("cleared", 18'h0_0000, read_data_out);
      for (int i = 0; i < 16; i++)
      begin
         far.put(18'h2_A000 + 18'(i));
         check_bit("ae", i + 1 >= DEF_OFFSET_4, almost_empty_flag);
         check_bit("af", 15 - i > DEF_OFFSET_4, almost_full_flag);
      end
      tick(1);
      input_width_select <= 1'h0;
      tick(8);
      check_word("widths held", 18'h0_0003, {16'h0000, width_cfg_out});
      for (int i = 0; i < 5; i++)
      begin
         mark_in <= i == 3;
         tick(4);
         mark_in <= 1'h0;
         read_check(1'h1, 18'h2_A000 + 18'(i));
      end
      retransmit_in <= 1'h1;
      far.get(1'h0);
      tick(1);
      retransmit_in <= 1'h0;
      read_check(1'h1, 18'h2_A003);
      offset_load <= 1'h0;
      tick(2);
      read_check(1'h1, {2'h0, DEF_OFFSET_4});
      offset_load <= 1'h1;
      tick(2);
      read_check(1'h1, 18'h2_A004);
      output_enable_n <= 1'h1;
      tick(4);
      check_bit("drive off", 1'h0, read_data_oe);
      output_enable_n <= 1'h0;
      partial_reset_in <= 1'h1;
      tick(8);
      check_bit("drive in reset", 1'h1, read_data_oe);
      check_word("partial", 18'h0_0000, read_data_out);
      partial_reset_in <= 1'h0;
      tick(6);
      check_word("widths kept", 18'h0_0003, {16'h0000, width_cfg_out});
      far.put(18'h2_B000);
      check_bit("offset kept", 1 >= DEF_OFFSET_4, almost_empty_flag);
      $display("wide test done");
      tick(1);
      // narrow output, async read, flags that move only on read strobes or resets
      mreset(1'h0, 7'h01);
      check_word("narrow", 18'h0_0000, {16'h0000, width_cfg_out});
      for (int i = 0; i < 7; i++)
         far.put(18'h2_B1A5 + 18'(i));
      check_bit("sync held", 0 >= DEF_OFFSET_0, almost_empty_flag);
      read_check(1'h0, 18'h0_01A5);
      check_bit("sync flag", 7 >= DEF_OFFSET_0, almost_empty_flag);
      read_check(1'h0, 18'h0_01A6);
      check_bit("default", 6 >= DEF_OFFSET_0, almost_empty_flag);
      $display("narrow test done");
      test_done();
   end
endmodule : tb_fifo_ctl
